// ### rtl/ragc_consts.svh
// register offsets, field positions, reset values for the rx gain loop
`ifndef RAGC_CONSTS_SVH
`define RAGC_CONSTS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define RAGC_ADDR_CONTROL 32'h400140c0
`define RAGC_ADDR_SETTINGS 32'h400140c4
`define RAGC_ADDR_STATUS 32'h400140c8
`define RAGC_ADDR_TABLE0 32'h400140cc
`define RAGC_ADDR_TABLE1 32'h400140d0
`define RAGC_ADDR_TABLE2 32'h400140d4
`define RAGC_ADDR_TABLE3 32'h400140d8

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define RAGC_CONTROL_RST 32'h00000003
`define RAGC_CONTROL_MASK 32'hf0000007
`define RAGC_SETTINGS_RST 32'h12011707
`define RAGC_TABLE_MASK 32'h7f7f7f7f
`define RAGC_TABLE0_RST 32'h00081040
`define RAGC_TABLE1_RST 32'h48505860
`define RAGC_TABLE2_RST 32'h61626364
`define RAGC_TABLE3_RST 32'h00000000

// ----------------------------------------
// field positions
// ----------------------------------------
`define RAGC_CTL_ENABLE 0
`define RAGC_CTL_ALLOW_FRZ 1
`define RAGC_CTL_FRZ_PRE 2
`define RAGC_CTL_START_HI 31
`define RAGC_CTL_START_LO 28
`define RAGC_SET_LOW_HI 31
`define RAGC_SET_LOW_LO 28
`define RAGC_SET_HIGH_HI 27
`define RAGC_SET_HIGH_LO 24
`define RAGC_SET_DIV_HI 23
`define RAGC_SET_DIV_LO 16
`define RAGC_SET_MEAS_HI 15
`define RAGC_SET_MEAS_LO 8
`define RAGC_SET_SETTLE_HI 7
`define RAGC_SET_SETTLE_LO 0
`define RAGC_STAT_STATE_LO 8

// ----------------------------------------
// gain state limits
// ----------------------------------------
`define RAGC_STATE_MIN 4'h0
`define RAGC_STATE_MAX 4'hb

`endif

// ### rtl/ragc_pkg.sv
// types shared by the rx gain loop
package ragc_pkg;
	typedef logic [3:0] ragc_state_t;
	typedef logic [6:0] ragc_setting_t;
	typedef enum logic [2:0] {
		RAGC_HOLD = 3'h1,
		RAGC_MEAS = 3'h2,
		RAGC_SETTLE = 3'h4
	} ragc_fsm_t;
endpackage

// ### rtl/ragc_top.sv
// receiver automatic gain control loop with its register file
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "ragc_consts.svh"

module ragc_top #(
	parameter int DIV_W = 8,
	parameter int MAG_W = 6
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// register port
	input wire logic [31:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// receive path events and signal level
	input wire logic [MAG_W-1:0] adc_atten_in,
	input wire logic preamble_det_in,
	input wire logic sfd_det_in,
	input wire logic rx_end_in,
	input wire logic edcca_end_in,
	// amplifier drive
	output logic [2:0] if_amp1_out,
	output logic [2:0] if_amp2_out,
	output logic if_amp3_out,
	output ragc_pkg::ragc_state_t gain_state_out,
	output logic frozen_out
);
	import ragc_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------

	// high threshold in dB below full scale
	function automatic logic [MAG_W-1:0] high_db(input logic [3:0] code);
		logic [MAG_W-1:0] v;
		v = {{(MAG_W-4){1'b0}}, code};
		high_db = (code == 4'h0) ? '0 : MAG_W'((v << 1) - 1'b1);
	endfunction

	// low threshold in dB below full scale, measured from the high one
	function automatic logic [MAG_W-1:0] low_db(input logic [3:0] lo,
		input logic [3:0] hi);
		logic [MAG_W-1:0] off;
		off = (lo <= 4'h4) ? MAG_W'(4'h9 - (lo << 1)) : MAG_W'(1);
		low_db = MAG_W'(high_db(hi) + off);
	endfunction

	// clamp any index to the twelve usable states
	function automatic ragc_state_t clamp_state(input logic [3:0] s);
		clamp_state = (s > `RAGC_STATE_MAX) ? `RAGC_STATE_MAX : s;
	endfunction

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rst_s1_q;
	logic rst_s2_q;
	logic rst_n;

	// two-stage release, assert is immediate
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_n = rst_s2_q;

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [31:0] ctl_q;
	logic [31:0] set_q;
	logic [31:0] tab_q [4];
	logic [31:0] stat_q;
	logic [31:0] rdata_d;
	logic ctl_wr_q;

	// control and settings writes
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctl_q <= `RAGC_CONTROL_RST;
			set_q <= `RAGC_SETTINGS_RST;
		end
		else if (reg_wr_in)
		begin
			if (reg_addr_in == `RAGC_ADDR_CONTROL)
				ctl_q <= reg_wdata_in & `RAGC_CONTROL_MASK;
			if (reg_addr_in == `RAGC_ADDR_SETTINGS)
				set_q <= reg_wdata_in;
		end
	end

	// flags a control write so the loop reloads the new start gain;
	// without it, start and enable written together would keep the old gain
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			ctl_wr_q <= 1'b0;
		else
			ctl_wr_q <= reg_wr_in
				&& (reg_addr_in == `RAGC_ADDR_CONTROL);
	end

	// gain table words, four settings each
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tab_q[0] <= `RAGC_TABLE0_RST;
			tab_q[1] <= `RAGC_TABLE1_RST;
			tab_q[2] <= `RAGC_TABLE2_RST;
			tab_q[3] <= `RAGC_TABLE3_RST;
		end
		else if (reg_wr_in)
		begin
			for (int i = 0; i < 4; i++)
				if (reg_addr_in == `RAGC_ADDR_TABLE0 + 32'(i * 4))
					tab_q[i] <= reg_wdata_in & `RAGC_TABLE_MASK;
		end
	end

	// read mux, unmapped addresses read zero
	always_comb
	begin
		rdata_d = 32'h00000000;
		unique case (reg_addr_in)
			`RAGC_ADDR_CONTROL: rdata_d = ctl_q;
			`RAGC_ADDR_SETTINGS: rdata_d = set_q;
			`RAGC_ADDR_STATUS: rdata_d = stat_q;
			`RAGC_ADDR_TABLE0: rdata_d = tab_q[0];
			`RAGC_ADDR_TABLE1: rdata_d = tab_q[1];
			`RAGC_ADDR_TABLE2: rdata_d = tab_q[2];
			`RAGC_ADDR_TABLE3: rdata_d = tab_q[3];
			default: rdata_d = 32'h00000000;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata_out <= 32'h00000000;
		else if (reg_rd_in)
			reg_rdata_out <= rdata_d;
		else
			reg_rdata_out <= 32'h00000000;
	end

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	logic en;
	logic allow_frz;
	logic frz_pre;
	ragc_state_t start_st;
	logic [DIV_W-1:0] div_f;
	logic [7:0] meas_f;
	logic [7:0] settle_f;
	logic [MAG_W-1:0] hi_db;
	logic [MAG_W-1:0] lo_db;
	logic restart;
	logic frz_evt;
	logic pkt_end;

	assign en = ctl_q[`RAGC_CTL_ENABLE];
	assign allow_frz = ctl_q[`RAGC_CTL_ALLOW_FRZ];
	assign frz_pre = ctl_q[`RAGC_CTL_FRZ_PRE];
	assign start_st = clamp_state(
		ctl_q[`RAGC_CTL_START_HI:`RAGC_CTL_START_LO]);
	assign div_f = DIV_W'(set_q[`RAGC_SET_DIV_HI:`RAGC_SET_DIV_LO]);
	assign meas_f = set_q[`RAGC_SET_MEAS_HI:`RAGC_SET_MEAS_LO];
	assign settle_f = set_q[`RAGC_SET_SETTLE_HI:`RAGC_SET_SETTLE_LO];
	assign hi_db = high_db(set_q[`RAGC_SET_HIGH_HI:`RAGC_SET_HIGH_LO]);
	assign lo_db = low_db(set_q[`RAGC_SET_LOW_HI:`RAGC_SET_LOW_LO],
		set_q[`RAGC_SET_HIGH_HI:`RAGC_SET_HIGH_LO]);
	assign pkt_end = rx_end_in | edcca_end_in;
	// loop restarts from the start gain while off, at packet end,
	// or right after a control write
	assign restart = !en | pkt_end | ctl_wr_q;
	// freeze trigger chosen by bit 2, gated by allow-freeze
	assign frz_evt = allow_frz
		& (frz_pre ? preamble_det_in : sfd_det_in);

	// ----------------------------------------
	// divided loop tick
	// ----------------------------------------
	logic [DIV_W-1:0] div_cnt_q;
	logic tick;

	assign tick = (div_cnt_q == div_f);

	// counts core clocks, one tick every divider plus one
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			div_cnt_q <= '0;
		else if (tick || div_cnt_q > div_f)
			div_cnt_q <= '0;
		else
			div_cnt_q <= div_cnt_q + 1'b1;
	end

	// ----------------------------------------
	// gain loop
	// ----------------------------------------
	ragc_fsm_t fsm_q;
	ragc_state_t gain_q;
	logic [7:0] win_q;
	logic [MAG_W-1:0] peak_q;
	logic frozen_q;

	// freeze flag, released at packet end or when freezing is barred
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			frozen_q <= 1'b0;
		else if (restart || !allow_frz)
			frozen_q <= 1'b0;
		else if (frz_evt)
			frozen_q <= 1'b1;
	end

	// measure, step, settle on each divided tick
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fsm_q <= RAGC_HOLD;
			gain_q <= `RAGC_STATE_MIN;
			win_q <= 8'h00;
			peak_q <= '1;
		end
		else if (restart)
		begin
			fsm_q <= en ? RAGC_MEAS : RAGC_HOLD;
			gain_q <= start_st;
			win_q <= 8'h00;
			peak_q <= '1;
		end
		else if (tick && !frozen_q)
		begin
			unique case (fsm_q)
				RAGC_HOLD:
				begin
					fsm_q <= RAGC_MEAS;
					win_q <= 8'h00;
					peak_q <= '1;
				end
				RAGC_MEAS:
				begin
					if (win_q == meas_f)
					begin
						// strongest sample decides the step
						if (adc_atten_in < peak_q ? adc_atten_in < hi_db
							: peak_q < hi_db)
						begin
							if (gain_q != `RAGC_STATE_MIN)
								gain_q <= gain_q - 1'b1;
						end
						else if ((adc_atten_in < peak_q ? adc_atten_in
							: peak_q) > lo_db)
						begin
							if (gain_q < `RAGC_STATE_MAX)
								gain_q <= gain_q + 1'b1;
						end
						fsm_q <= RAGC_SETTLE;
						win_q <= 8'h00;
					end
					else
					begin
						win_q <= win_q + 1'b1;
						if (adc_atten_in < peak_q)
							peak_q <= adc_atten_in;
					end
				end
				RAGC_SETTLE:
				begin
					if (win_q == settle_f)
					begin
						fsm_q <= RAGC_MEAS;
						win_q <= 8'h00;
						peak_q <= '1;
					end
					else
						win_q <= win_q + 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// amplifier drive and status
	// ----------------------------------------
	ragc_setting_t cur_set;

	// pick the setting of the current state; word 3 is never reached
	always_comb
	begin
		cur_set = '0;
		unique case (gain_q[3:2])
			2'h0: cur_set = tab_q[0][(3 - gain_q[1:0]) * 8 +: 7];
			2'h1: cur_set = tab_q[1][(3 - gain_q[1:0]) * 8 +: 7];
			2'h2: cur_set = tab_q[2][(3 - gain_q[1:0]) * 8 +: 7];
			2'h3: cur_set = '0;
		endcase
	end

	// amplifier outputs come straight from flops
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			if_amp1_out <= 3'h0;
			if_amp2_out <= 3'h0;
			if_amp3_out <= 1'b0;
			gain_state_out <= `RAGC_STATE_MIN;
			frozen_out <= 1'b0;
		end
		else
		begin
			if_amp1_out <= cur_set[2:0];
			if_amp2_out <= cur_set[5:3];
			if_amp3_out <= cur_set[6];
			gain_state_out <= gain_q;
			frozen_out <= frozen_q;
		end
	end

	// status captured at packet or energy/CCA end
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			stat_q <= 32'h00000000;
		else if (pkt_end)
			stat_q <= {20'h00000, gain_q, 1'b0, cur_set};
	end

endmodule

// ### verification/ragc_rf_model.sv
// loose model of the if amplifier chain and the adc level detector
`timescale 1ns/1ps
module ragc_rf_model (
	// amplifier settings
	input wire logic [2:0] amp1_in,
	input wire logic [2:0] amp2_in,
	input wire logic amp3_in,
	// source level, db below full scale
	input wire logic [5:0] src_in,
	// level seen by the loop
	output logic [5:0] atten_out
);
	logic [6:0] gain_db;
	logic [5:0] g8;
	// stage coding: 6 db steps, top bit set is 24 db
	function automatic logic [6:0] stage_db(input logic [2:0] c);
		return c[2] ? 7'h18 : 7'(c[1:0]) * 7'h6;
	endfunction
	// coupling divided by eight so the loop can reach both ends
	always_comb
	begin
		gain_db = (amp3_in ? 7'h12 : 7'h0) + stage_db(amp2_in)
			+ stage_db(amp1_in);
		g8 = {2'h0, gain_db[6:3]};
		atten_out = (src_in > g8) ? src_in - g8 : 6'h0;
	end
endmodule

// ### verification/ragc_monitor.sv
// port checker for the rx gain loop
`timescale 1ns/1ps
`include "ragc_consts.svh"
module ragc_monitor (
	// clock, reset, register port
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [31:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	// events and loop outputs
	input wire logic preamble_det_in,
	input wire logic sfd_det_in,
	input wire logic rx_end_in,
	input wire logic edcca_end_in,
	input wire logic [2:0] if_amp1_out,
	input wire logic [2:0] if_amp2_out,
	input wire logic if_amp3_out,
	input wire ragc_pkg::ragc_state_t gain_state_out,
	input wire logic frozen_out
);
	import ragc_pkg::*;
	logic [31:0] ctl_q;
	logic [2:0] quiet_q;
	logic [3:0] start_w;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// shadow of the control word
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			ctl_q <= `RAGC_CONTROL_RST;
		else if (reg_wr_in && reg_addr_in == `RAGC_ADDR_CONTROL)
			ctl_q <= reg_wdata_in & `RAGC_CONTROL_MASK;
	end
	// cycles since the last restart cause, saturating
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			quiet_q <= 3'h0;
		else if ((reg_wr_in && reg_addr_in == `RAGC_ADDR_CONTROL)
			|| rx_end_in || edcca_end_in)
			quiet_q <= 3'h0;
		else if (quiet_q != 3'h7)
			quiet_q <= quiet_q + 3'h1;
	end
	assign start_w = (ctl_q[31:28] > 4'hb) ? 4'hb : ctl_q[31:28];
	state_range_a: assert property (gain_state_out <= 4'hb)
		else $error("gain state above eleven");
	rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 0)
		else $error("read data outside its cycle");
	hold_start_a: assert property ((!ctl_q[0] && quiet_q >= 3'h3)
		|-> gain_state_out == start_w) else $error("held gain not start");
	step_one_a: assert property (quiet_q >= 3'h3 |->
		(gain_state_out - $past(gain_state_out)) inside {4'h0, 4'h1, 4'hf})
		else $error("gain jumped");
	no_freeze_a: assert property ((!ctl_q[1] && quiet_q >= 3'h3)
		|-> !frozen_out) else $error("frozen without permission");
	frozen_hold_a: assert property ((frozen_out && $past(frozen_out))
		|-> $stable(gain_state_out)) else $error("gain moved while frozen");
	freeze_src_a: assert property (($rose(frozen_out) && quiet_q >= 3'h3)
		|-> ($past(ctl_q[2]) ? ($past(preamble_det_in) ||
		$past(preamble_det_in, 2)) : ($past(sfd_det_in) ||
		$past(sfd_det_in, 2)))) else $error("freeze from wrong event");
	amps_follow_a: assert property (($stable(gain_state_out) &&
		$past($stable(gain_state_out)) && !$past(reg_wr_in) &&
		!$past(reg_wr_in, 2)) |-> $stable({if_amp3_out, if_amp2_out,
		if_amp1_out})) else $error("amps moved without cause");
endmodule
bind ragc_top ragc_monitor ragc_monitor_inst (.clk_in(clk_in),
	.rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.preamble_det_in(preamble_det_in), .sfd_det_in(sfd_det_in),
	.rx_end_in(rx_end_in), .edcca_end_in(edcca_end_in),
	.if_amp1_out(if_amp1_out), .if_amp2_out(if_amp2_out),
	.if_amp3_out(if_amp3_out), .gain_state_out(gain_state_out),
	.frozen_out(frozen_out));

// ### verification/tb_top.sv
// self-checking bench for the rx gain loop
`timescale 1ns/1ps
`include "ragc_consts.svh"
module tb_top;
	import ragc_pkg::*;
	localparam logic [6:0] TBL [12] = '{7'h00, 7'h08, 7'h10, 7'h40,
		7'h48, 7'h50, 7'h58, 7'h60, 7'h61, 7'h62, 7'h63, 7'h64};
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [31:0] addr = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic pre = 1'b0;
	logic sfd = 1'b0;
	logic rxe = 1'b0;
	logic ede = 1'b0;
	logic [5:0] src = 6'h3f;
	logic [31:0] rdata;
	logic [5:0] atten;
	logic [2:0] a1;
	logic [2:0] a2;
	logic a3;
	ragc_state_t st;
	ragc_state_t g;
	logic frz;
	int mismatches = 0;
	int checked = 0;
	int n;
	always #20 clk_in = ~clk_in;
	ragc_top ragc_top_inst (.clk_in(clk_in), .rstn_in(rstn_in),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .adc_atten_in(atten),
		.preamble_det_in(pre), .sfd_det_in(sfd), .rx_end_in(rxe),
		.edcca_end_in(ede), .if_amp1_out(a1), .if_amp2_out(a2),
		.if_amp3_out(a3), .gain_state_out(st), .frozen_out(frz));
	ragc_rf_model ragc_rf_model_inst (.amp1_in(a1), .amp2_in(a2),
		.amp3_in(a3), .src_in(src), .atten_out(atten));
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// register port cycles
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_in);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		@(posedge clk_in);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_in);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	// one-cycle event: 0 preamble, 1 delimiter, 2 packet end, 3 ed/cca end
	task automatic pulse(input int k);
		@(posedge clk_in);
		{ede, rxe, sfd, pre} <= 4'(1 << k);
		@(posedge clk_in);
		{ede, rxe, sfd, pre} <= 4'h0;
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge clk_in);
		#1;
	endtask
	task automatic wait_st(input ragc_state_t t);
		n = 0;
		while (st !== t && n < 2000)
		begin
			idle(1);
			n++;
		end
		chk(st, t);
		if (n == 2000)
			test_done();
	endtask
	task automatic t_regs();
		rd_chk(`RAGC_ADDR_CONTROL, 32'h00000003);
		rd_chk(`RAGC_ADDR_SETTINGS, 32'h12011707);
		rd_chk(`RAGC_ADDR_TABLE0, 32'h00081040);
		rd_chk(`RAGC_ADDR_TABLE1, 32'h48505860);
		rd_chk(`RAGC_ADDR_TABLE2, 32'h61626364);
		rd_chk(`RAGC_ADDR_TABLE3, 32'h0);
		rd_chk(32'h400140dc, 32'h0);
		wr_reg(`RAGC_ADDR_TABLE3, 32'hffffffff);
		rd_chk(`RAGC_ADDR_TABLE3, 32'h7f7f7f7f);
		$display("t_regs done");
	endtask
	task automatic t_hold();
		wr_reg(`RAGC_ADDR_CONTROL, 32'h50000000);
		idle(4);
		chk(st, 5);
		chk({a3, a2, a1}, TBL[5]);
		wr_reg(`RAGC_ADDR_CONTROL, 32'hf0000000);
		idle(4);
		chk(st, 11);
		chk({a3, a2, a1}, TBL[11]);
		$display("t_hold done");
	endtask
	task automatic t_loop();
		wr_reg(`RAGC_ADDR_SETTINGS, 32'h31000000);
		wr_reg(`RAGC_ADDR_CONTROL, 32'h30000001);
		src <= 6'h0;
		wait_st(0);
		@(posedge clk_in);
		src <= 6'h3f;
		wait_st(11);
		idle(20);
		chk(st, 11);
		wr_reg(`RAGC_ADDR_SETTINGS, 32'h30010102);
		wr_reg(`RAGC_ADDR_CONTROL, 32'h00000001);
		wait_st(1);
		n = 0;
		while (st !== 4'h2 && n < 100)
		begin
			idle(1);
			n++;
		end
		chk(n, 10);
		if (n == 100)
			test_done();
		$display("t_loop done");
	endtask
	task automatic t_freeze();
		wr_reg(`RAGC_ADDR_SETTINGS, 32'h30000000);
		wr_reg(`RAGC_ADDR_CONTROL, 32'h60000007);
		pulse(0);
		idle(3);
		chk(frz, 1);
		g = st;
		idle(10);
		chk(st, g);
		pulse(2);
		idle(2);
		rd_chk(`RAGC_ADDR_STATUS, 32'({g, 1'b0, TBL[g]}));
		chk(frz, 0);
		pulse(1);
		idle(3);
		chk(frz, 0);
		wr_reg(`RAGC_ADDR_CONTROL, 32'h60000005);
		pulse(0);
		idle(3);
		chk(frz, 0);
		wr_reg(`RAGC_ADDR_CONTROL, 32'h60000003);
		pulse(1);
		idle(3);
		chk(frz, 1);
		g = st;
		pulse(3);
		idle(2);
		rd_chk(`RAGC_ADDR_STATUS, 32'({g, 1'b0, TBL[g]}));
		chk(frz, 0);
		wr_reg(`RAGC_ADDR_CONTROL, 32'h60000001);
		pulse(1);
		idle(3);
		chk(frz, 0);
		$display("t_freeze done");
	endtask
	// verdict and end of run
	task automatic test_done();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
		idle(3);
		t_regs();
		t_hold();
		t_loop();
		t_freeze();
		test_done();
	end
endmodule
